// file: tpan_map.svh
// register offsets, field positions, reset values and frame counts
`ifndef TPAN_MAP_SVH
`define TPAN_MAP_SVH

// ****************************************
// management frame
// ****************************************
`define TPAN_DEVAD 5'h07
`define TPAN_PREAMBLE_ONES 6'd32
`define TPAN_HDR_LAST 4'd13
`define TPAN_DATA_LAST 4'd15
`define TPAN_OP_ADDR 2'b00
`define TPAN_OP_WRITE 2'b01
`define TPAN_OP_RINC 2'b10
`define TPAN_OP_READ 2'b11

// ****************************************
// register offsets
// ****************************************
`define TPAN_OFF_PKG_LO 16'h000e
`define TPAN_OFF_PKG_HI 16'h000f
`define TPAN_OFF_BASE 16'h0010
`define TPAN_OFF_LP_BASE 16'h0013
`define TPAN_OFF_TX1 16'h0016
`define TPAN_OFF_TX2 16'h0017
`define TPAN_OFF_TX3 16'h0018
`define TPAN_OFF_RX1 16'h0019
`define TPAN_OFF_RX2 16'h001a
`define TPAN_OFF_RX3 16'h001b
`define TPAN_OFF_CTRL 16'h0020

// ****************************************
// fields and reset values
// ****************************************
`define TPAN_BASE_ACK 14
`define TPAN_BASE_WR_MASK 16'hbfff
`define TPAN_BASE_RST 16'h1000
`define TPAN_TX1_TOGGLE 11
`define TPAN_TX1_WR_MASK 16'hb7ff
`define TPAN_CTRL_MAN_EN 15
`define TPAN_CTRL_MAN_VAL 14
`define TPAN_CTRL_PORT 13
`define TPAN_CTRL_TEN 12
`define TPAN_CTRL_FIVE 8
`define TPAN_CTRL_TWO_HALF 7
`define TPAN_CTRL_FR_FIVE 6
`define TPAN_CTRL_FR_TWO_HALF 5
`define TPAN_CTRL_PRBS 2
`define TPAN_CTRL_LOOP 0
`define TPAN_CTRL_WR_MASK 16'hf1e4
`define TPAN_CTRL_RST 16'h1004
`define TPAN_WORD_RST 16'h0000

`endif

// file: tpan_pkg.sv
// types shared by the auto-negotiation register bank
package tpan_pkg;

  // ****************************************
  // management frame states
  // ****************************************
  typedef enum logic [3:0] {
    TPAN_PRE = 4'b0001,
    TPAN_HDR = 4'b0010,
    TPAN_TA = 4'b0100,
    TPAN_DATA = 4'b1000
  } tpan_frame_t;

  // ****************************************
  // role requested from the negotiation engine
  // ****************************************
  typedef enum logic [1:0] {
    TPAN_ROLE_AUTO = 2'h0,
    TPAN_ROLE_SLAVE = 2'h1,
    TPAN_ROLE_MASTER = 2'h2
  } tpan_role_t;

endpackage : tpan_pkg

// file: tpan_mgmt_if.sv
// access strobes between the management slave and the register bank
interface tpan_mgmt_if;
  logic ld_addr;
  logic wr;
  logic rd;
  logic rinc;
  logic [15:0] wdata;
  logic [15:0] rdata;

  modport slave (output ld_addr, output wr, output rd, output rinc, output wdata,
    input rdata);
  modport bank (input ld_addr, input wr, input rd, input rinc, input wdata,
    output rdata);
endinterface : tpan_mgmt_if

// file: tpan_mdio_slave.sv
// management frame slave: decodes address, write and read frames
`include "tpan_map.svh"
module tpan_mdio_slave #(
  parameter logic [4:0] PORT_ADDR = 5'h00
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // register access
  tpan_mgmt_if.slave mg
);

  logic mdc_meta_ff, mdc_sync_ff, mdc_last_ff, dio_meta_ff, dio_sync_ff;
  logic rise, fall, is_read_ff, match_ff;
  logic [5:0] ones_ff;
  logic [3:0] cnt_ff;
  logic [13:0] hdr_ff;
  logic [15:0] shf_ff;
  logic [1:0] op_ff;
  tpan_pkg::tpan_frame_t st_ff;
  logic [13:0] hdr_now;

  // two stages before anything looks at the pins
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mdc_meta_ff <= 1'b1; // idle high, so no false rise after reset
      mdc_sync_ff <= 1'b1;
      mdc_last_ff <= 1'b1;
      dio_meta_ff <= 1'b1;
      dio_sync_ff <= 1'b1;
    end else begin
      mdc_meta_ff <= mdc;
      mdc_sync_ff <= mdc_meta_ff;
      mdc_last_ff <= mdc_sync_ff;
      dio_meta_ff <= mdio_in;
      dio_sync_ff <= dio_meta_ff;
    end
  end

  assign rise = mdc_sync_ff & ~mdc_last_ff;
  assign fall = ~mdc_sync_ff & mdc_last_ff;
  assign hdr_now = {hdr_ff[12:0], dio_sync_ff};

  // frame walk on rising edges of the management clock
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= tpan_pkg::TPAN_PRE;
      ones_ff <= 6'd0;
      cnt_ff <= 4'd0;
      hdr_ff <= 14'h0000;
      op_ff <= 2'b00;
      match_ff <= 1'b0;
      is_read_ff <= 1'b0;
    end else if (rise) begin
      case (st_ff)
        tpan_pkg::TPAN_PRE: begin
          if (dio_sync_ff) begin
            if (ones_ff != `TPAN_PREAMBLE_ONES) ones_ff <= ones_ff + 6'd1;
          end else begin
            if (ones_ff == `TPAN_PREAMBLE_ONES) begin
              st_ff <= tpan_pkg::TPAN_HDR;
              cnt_ff <= 4'd1;
              hdr_ff <= 14'h0000;
            end
            ones_ff <= 6'd0;
          end
        end
        tpan_pkg::TPAN_HDR: begin
          hdr_ff <= hdr_now;
          cnt_ff <= cnt_ff + 4'd1;
          if (cnt_ff == `TPAN_HDR_LAST) begin
            st_ff <= tpan_pkg::TPAN_TA;
            cnt_ff <= 4'd0;
            op_ff <= hdr_now[11:10];
            // start bits, port and device must all match
            match_ff <= (hdr_now[13:12] == 2'b00) && (hdr_now[9:5] == PORT_ADDR) &&
              (hdr_now[4:0] == `TPAN_DEVAD);
            is_read_ff <= hdr_now[11];
          end
        end
        tpan_pkg::TPAN_TA: begin
          cnt_ff <= cnt_ff + 4'd1;
          if (cnt_ff == 4'd1) begin
            st_ff <= tpan_pkg::TPAN_DATA;
            cnt_ff <= 4'd0;
          end
        end
        tpan_pkg::TPAN_DATA: begin
          cnt_ff <= cnt_ff + 4'd1;
          if (cnt_ff == `TPAN_DATA_LAST) st_ff <= tpan_pkg::TPAN_PRE;
        end
        default: st_ff <= tpan_pkg::TPAN_PRE;
      endcase
    end
  end

  // one-cycle strobes into the bank; reads fire early so data is ready by turnaround
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mg.ld_addr <= 1'b0;
      mg.wr <= 1'b0;
      mg.rd <= 1'b0;
      mg.rinc <= 1'b0;
    end else begin
      mg.rd <= rise && st_ff == tpan_pkg::TPAN_TA && cnt_ff == 4'd0 && match_ff && is_read_ff;
      mg.rinc <= rise && st_ff == tpan_pkg::TPAN_DATA && cnt_ff == `TPAN_DATA_LAST &&
        match_ff && op_ff == `TPAN_OP_RINC;
      mg.wr <= rise && st_ff == tpan_pkg::TPAN_DATA && cnt_ff == `TPAN_DATA_LAST &&
        match_ff && op_ff == `TPAN_OP_WRITE;
      mg.ld_addr <= rise && st_ff == tpan_pkg::TPAN_DATA && cnt_ff == `TPAN_DATA_LAST &&
        match_ff && op_ff == `TPAN_OP_ADDR;
    end
  end

  // data shifter: in for writes on rises, out for reads on falls
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shf_ff <= 16'h0000;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
    end else if (rise && st_ff == tpan_pkg::TPAN_DATA) begin
      if (!is_read_ff) shf_ff <= {shf_ff[14:0], dio_sync_ff};
      if (cnt_ff == `TPAN_DATA_LAST) mdio_oe <= 1'b0;
    end else if (fall && match_ff && is_read_ff) begin
      if (st_ff == tpan_pkg::TPAN_TA && cnt_ff == 4'd1) begin
        shf_ff <= mg.rdata;
        mdio_out <= 1'b0;
        mdio_oe <= 1'b1;
      end else if (st_ff == tpan_pkg::TPAN_DATA) begin
        mdio_out <= shf_ff[15];
        shf_ff <= {shf_ff[14:0], 1'b0};
      end
    end
  end

  assign mg.wdata = shf_ff;

endmodule : tpan_mdio_slave

// file: tpan_partner_pages.sv
// holds the link partner's base page and extended next page words
module tpan_partner_pages (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // captures from the negotiation engine
  input wire logic base_load,
  input wire logic [15:0] base_word,
  input wire logic xnp_load,
  input wire logic [15:0] xnp_word1,
  input wire logic [15:0] xnp_word2,
  input wire logic [15:0] xnp_word3,
  // software writes
  input wire logic sw_wr2,
  input wire logic sw_wr3,
  input wire logic [15:0] sw_wdata,
  // held words
  output logic [15:0] base_ff,
  output logic [15:0] rx1_ff,
  output logic [15:0] rx2_ff,
  output logic [15:0] rx3_ff
);

  // base page keeps the local layout; bit 12 shows extended page ability
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) base_ff <= 16'h0000;
    else if (base_load) base_ff <= base_word;
  end

  // partner page capture wins over a software write in the same cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx1_ff <= 16'h0000;
      rx2_ff <= 16'h0000;
      rx3_ff <= 16'h0000;
    end else if (xnp_load) begin
      rx1_ff <= xnp_word1;
      rx2_ff <= xnp_word2;
      rx3_ff <= xnp_word3;
    end else begin
      if (sw_wr2) rx2_ff <= sw_wdata;
      if (sw_wr3) rx3_ff <= sw_wdata;
    end
  end

endmodule : tpan_partner_pages

// file: tpan_regs.sv
// twisted-pair auto-negotiation register bank behind the management pins
//
// Behaviour
// - The 32-bit package identifier reads as bits 15:0 at 0x0e and bits 31:16 at 0x0f.
// - The local base page holds next page, read-only ack, remote fault, extended page, ability, selector.
// - The partner base page uses the local layout and bit 12 shows extended page ability.
// - Transmit word 1 holds next page, message, ack 2, a device-kept toggle and code bits 10:0.
// - Transmit and partner words 2 and 3 carry code bits 26:11 and 42:27.
// - Partner extended page word 1 is read-only: next page, ack, message, ack 2, toggle, code.
// - Control bit 15 set enables manual master/slave choice, reset clears it.
// - With manual choice, control bit 14 picks master when 1 and slave when 0.
// - Control bit 13 advertises multiport when 1 and single port when 0.
// - Control bit 12 decides whether ten-gigabit ability is advertised.
// - Control bits 8 and 7 advertise five and two-and-a-half gigabit ability.
// - Control bits 6 and 5 advertise quick retrain at five and two-and-a-half gigabit.
// - Control bit 2 asks the partner to reset training PRBS each frame, reset value 1.
// - Control bit 0 is read-only latched loop-timing advertisement, reset value 1.
// - The partner ten-gigabit ability counts only once a page has been received.
`include "tpan_map.svh"
module tpan_regs #(
  // arbitrary neutral value for the package identifier
  parameter logic [31:0] PKG_IDENT = 32'h5a3c_0e71,
  parameter logic [4:0] PORT_ADDR = 5'h00
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // management pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // from the negotiation engine
  input wire logic base_ack_in,
  input wire logic lp_base_load,
  input wire logic [15:0] lp_base_word,
  input wire logic lp_xnp_load,
  input wire logic [15:0] lp_xnp_word1,
  input wire logic [15:0] lp_xnp_word2,
  input wire logic [15:0] lp_xnp_word3,
  input wire logic xnp_sent,
  input wire logic page_received,
  input wire logic lp_ten_gig_in,
  input wire logic loop_timing_cap,
  // to the negotiation engine
  output logic [15:0] base_page_adv,
  output logic [15:0] xnp_tx_word1,
  output logic [15:0] xnp_tx_word2,
  output logic [15:0] xnp_tx_word3,
  output logic [15:0] ctrl_word,
  output tpan_pkg::tpan_role_t role_request,
  output logic lp_ten_gig_valid
);

  // ****************************************
  // management access
  // ****************************************
  tpan_mgmt_if mg ();

  logic mdio_out_w;
  logic mdio_oe_w;

  tpan_mdio_slave #(.PORT_ADDR(PORT_ADDR)) u_slave (
    .clock(clock),
    .rst_b(rst_b),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out_w),
    .mdio_oe(mdio_oe_w),
    .mg(mg.slave)
  );

  // both come from flops inside the slave
  assign mdio_out = mdio_out_w;
  assign mdio_oe = mdio_oe_w;

  logic [15:0] addr_ff, rdata_ff, base_ff, tx1_ff, tx2_ff, tx3_ff, ctrl_ff;
  logic loop_ff;
  logic ten_valid_ff;
  tpan_pkg::tpan_role_t role_ff;
  logic [15:0] lp_base;
  logic [15:0] rx1;
  logic [15:0] rx2;
  logic [15:0] rx3;
  logic [15:0] nxt_rdata;
  logic [15:0] ctrl_view;
  logic wr_base;
  logic wr_tx1;
  logic wr_tx2;
  logic wr_tx3;
  logic wr_rx2;
  logic wr_rx3;
  logic wr_ctrl;
  logic rd_ctrl;

  // address pointer: loaded by address frames, stepped after post-read-increment
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) addr_ff <= 16'h0000;
    else if (mg.ld_addr) addr_ff <= mg.wdata;
    else if (mg.rinc) addr_ff <= addr_ff + 16'h0001;
  end

  // write decode
  assign wr_base = mg.wr && addr_ff == `TPAN_OFF_BASE;
  assign wr_tx1 = mg.wr && addr_ff == `TPAN_OFF_TX1;
  assign wr_tx2 = mg.wr && addr_ff == `TPAN_OFF_TX2;
  assign wr_tx3 = mg.wr && addr_ff == `TPAN_OFF_TX3;
  assign wr_rx2 = mg.wr && addr_ff == `TPAN_OFF_RX2;
  assign wr_rx3 = mg.wr && addr_ff == `TPAN_OFF_RX3;
  assign wr_ctrl = mg.wr && addr_ff == `TPAN_OFF_CTRL;
  assign rd_ctrl = mg.rd && addr_ff == `TPAN_OFF_CTRL;

  // ****************************************
  // partner pages
  // ****************************************
  tpan_partner_pages u_partner (
    .clock(clock),
    .rst_b(rst_b),
    .base_load(lp_base_load),
    .base_word(lp_base_word),
    .xnp_load(lp_xnp_load),
    .xnp_word1(lp_xnp_word1),
    .xnp_word2(lp_xnp_word2),
    .xnp_word3(lp_xnp_word3),
    .sw_wr2(wr_rx2),
    .sw_wr3(wr_rx3),
    .sw_wdata(mg.wdata),
    .base_ff(lp_base),
    .rx1_ff(rx1),
    .rx2_ff(rx2),
    .rx3_ff(rx3)
  );

  // ****************************************
  // local pages
  // ****************************************

  // base page: writable bits take software, ack follows the engine
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      base_ff <= `TPAN_BASE_RST;
    end else begin
      if (wr_base) base_ff <= mg.wdata & `TPAN_BASE_WR_MASK;
      else base_ff <= base_ff & `TPAN_BASE_WR_MASK;
      base_ff[`TPAN_BASE_ACK] <= base_ack_in;
    end
  end

  // word 1: toggle flips per page sent and is never written by software
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx1_ff <= `TPAN_WORD_RST;
    end else begin
      if (wr_tx1) tx1_ff <= mg.wdata & `TPAN_TX1_WR_MASK;
      else tx1_ff <= tx1_ff & `TPAN_TX1_WR_MASK;
      if (xnp_sent) tx1_ff[`TPAN_TX1_TOGGLE] <= ~tx1_ff[`TPAN_TX1_TOGGLE];
      else tx1_ff[`TPAN_TX1_TOGGLE] <= tx1_ff[`TPAN_TX1_TOGGLE];
    end
  end

  // words 2 and 3 extend the code to 43 bits
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx2_ff <= `TPAN_WORD_RST;
      tx3_ff <= `TPAN_WORD_RST;
    end else begin
      if (wr_tx2) tx2_ff <= mg.wdata;
      if (wr_tx3) tx3_ff <= mg.wdata;
    end
  end

  // ****************************************
  // control
  // ****************************************

  // reserved and latched bits never store software data
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) ctrl_ff <= `TPAN_CTRL_RST & `TPAN_CTRL_WR_MASK;
    else if (wr_ctrl) ctrl_ff <= mg.wdata & `TPAN_CTRL_WR_MASK;
  end

  // loop timing latches high; a read re-arms it, a new set wins over that read
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) loop_ff <= 1'b1;
    else if (loop_timing_cap) loop_ff <= 1'b1;
    else if (rd_ctrl) loop_ff <= 1'b0;
  end

  assign ctrl_view = {ctrl_ff[15:1], loop_ff};

  // role handed to the resolution logic; automatic unless forced
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) role_ff <= tpan_pkg::TPAN_ROLE_AUTO;
    else if (!ctrl_ff[`TPAN_CTRL_MAN_EN]) role_ff <= tpan_pkg::TPAN_ROLE_AUTO;
    else if (ctrl_ff[`TPAN_CTRL_MAN_VAL]) role_ff <= tpan_pkg::TPAN_ROLE_MASTER;
    else role_ff <= tpan_pkg::TPAN_ROLE_SLAVE;
  end

  // partner ability is meaningless before a page arrives, so it is held low
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) ten_valid_ff <= 1'b0;
    else ten_valid_ff <= page_received & lp_ten_gig_in;
  end

  // ****************************************
  // read path
  // ****************************************

  // unmapped offsets read zero
  always_comb begin
    nxt_rdata = 16'h0000;
    if (addr_ff == `TPAN_OFF_PKG_LO) nxt_rdata = PKG_IDENT[15:0];
    else if (addr_ff == `TPAN_OFF_PKG_HI) nxt_rdata = PKG_IDENT[31:16];
    else if (addr_ff == `TPAN_OFF_BASE) nxt_rdata = base_ff;
    else if (addr_ff == `TPAN_OFF_LP_BASE) nxt_rdata = lp_base;
    else if (addr_ff == `TPAN_OFF_TX1) nxt_rdata = tx1_ff;
    else if (addr_ff == `TPAN_OFF_TX2) nxt_rdata = tx2_ff;
    else if (addr_ff == `TPAN_OFF_TX3) nxt_rdata = tx3_ff;
    else if (addr_ff == `TPAN_OFF_RX1) nxt_rdata = rx1;
    else if (addr_ff == `TPAN_OFF_RX2) nxt_rdata = rx2;
    else if (addr_ff == `TPAN_OFF_RX3) nxt_rdata = rx3;
    else if (addr_ff == `TPAN_OFF_CTRL) nxt_rdata = ctrl_view;
  end

  // read data is frozen at the strobe so the shifter sees one value
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) rdata_ff <= 16'h0000;
    else if (mg.rd) rdata_ff <= nxt_rdata;
  end

  assign mg.rdata = rdata_ff;

  // outputs, each a flop
  assign base_page_adv = base_ff;
  assign xnp_tx_word1 = tx1_ff;
  assign xnp_tx_word2 = tx2_ff;
  assign xnp_tx_word3 = tx3_ff;
  assign ctrl_word = ctrl_view;
  assign role_request = role_ff;
  assign lp_ten_gig_valid = ten_valid_ff;

  // ****************************************
  // checks
  // ****************************************
  // fixed words, local pages and the partner base page
  a_pkg_low_read: assert property (@(posedge clock) disable iff (!rst_b)
    mg.rd && addr_ff == `TPAN_OFF_PKG_LO |=>
      rdata_ff == PKG_IDENT[15:0])
    else $error("package ident low word read wrong");

  a_pkg_high_read: assert property (@(posedge clock) disable iff (!rst_b)
    mg.rd && addr_ff == `TPAN_OFF_PKG_HI |=>
      rdata_ff == PKG_IDENT[31:16])
    else $error("package ident high word read wrong");

  a_base_ack_follows: assert property (@(posedge clock) disable iff (!rst_b)
    wr_base |=>
      base_ff[`TPAN_BASE_ACK] == $past(base_ack_in))
    else $error("base page ack taken from software");

  a_partner_base_load: assert property (@(posedge clock) disable iff (!rst_b)
    lp_base_load |=>
      lp_base == $past(lp_base_word))
    else $error("partner base page not captured");

  a_toggle_flips: assert property (@(posedge clock) disable iff (!rst_b)
    xnp_sent |=>
      tx1_ff[`TPAN_TX1_TOGGLE] != $past(tx1_ff[`TPAN_TX1_TOGGLE]))
    else $error("toggle did not flip on page sent");

  a_code_mid_write: assert property (@(posedge clock) disable iff (!rst_b)
    wr_tx2 |=>
      tx2_ff == $past(mg.wdata) ##1 xnp_tx_word2 == $past(tx2_ff))
    else $error("middle code word not stored");

  // partner words
  a_code_rx_capture: assert property (@(posedge clock) disable iff (!rst_b)
    lp_xnp_load |=>
      rx2 == $past(lp_xnp_word2) && rx3 == $past(lp_xnp_word3))
    else $error("partner code words not captured");

  a_rx1_read_only: assert property (@(posedge clock) disable iff (!rst_b)
    !lp_xnp_load |=>
      rx1 == $past(rx1))
    else $error("partner word 1 changed without capture");

  // control and role
  a_role_manual: assert property (@(posedge clock) disable iff (!rst_b)
    ctrl_ff[`TPAN_CTRL_MAN_EN] && ctrl_ff[`TPAN_CTRL_MAN_VAL] |=>
      role_request == tpan_pkg::TPAN_ROLE_MASTER)
    else $error("manual master not requested");

  a_role_slave: assert property (@(posedge clock) disable iff (!rst_b)
    ctrl_ff[`TPAN_CTRL_MAN_EN] && !ctrl_ff[`TPAN_CTRL_MAN_VAL] |=>
      role_request == tpan_pkg::TPAN_ROLE_SLAVE)
    else $error("manual slave not requested");

  a_role_auto: assert property (@(posedge clock) disable iff (!rst_b)
    !ctrl_ff[`TPAN_CTRL_MAN_EN] |=>
      role_request == tpan_pkg::TPAN_ROLE_AUTO)
    else $error("role forced without manual enable");

  a_port_type_write: assert property (@(posedge clock) disable iff (!rst_b)
    wr_ctrl |=>
      ctrl_word[`TPAN_CTRL_PORT] == $past(mg.wdata[`TPAN_CTRL_PORT]))
    else $error("port type bit not stored");

  a_ten_adv_write: assert property (@(posedge clock) disable iff (!rst_b)
    wr_ctrl |=>
      ctrl_word[`TPAN_CTRL_TEN] == $past(mg.wdata[`TPAN_CTRL_TEN]))
    else $error("ten gig advert bit not stored");

  a_speed_adv_write: assert property (@(posedge clock) disable iff (!rst_b)
    wr_ctrl |=>
      ctrl_word[8:7] == $past(mg.wdata[8:7]))
    else $error("speed advert bits not stored");

  a_retrain_adv_write: assert property (@(posedge clock) disable iff (!rst_b)
    wr_ctrl |=>
      ctrl_word[6:5] == $past(mg.wdata[6:5]))
    else $error("quick retrain bits not stored");

  a_loop_latched: assert property (@(posedge clock) disable iff (!rst_b)
    loop_timing_cap |=>
      ctrl_word[`TPAN_CTRL_LOOP] ##1 (ctrl_word[`TPAN_CTRL_LOOP] || $past(rd_ctrl)))
    else $error("loop timing advert not latched");

  a_loop_clear_read: assert property (@(posedge clock) disable iff (!rst_b)
    rd_ctrl && !loop_timing_cap |=>
      !ctrl_word[`TPAN_CTRL_LOOP])
    else $error("loop timing advert not cleared by read");

  a_ten_valid_gate: assert property (@(posedge clock) disable iff (!rst_b)
    !page_received |=>
      !lp_ten_gig_valid)
    else $error("partner ten gig shown before page received");

  a_ten_valid_set: assert property (@(posedge clock) disable iff (!rst_b)
    page_received && lp_ten_gig_in |=>
      lp_ten_gig_valid)
    else $error("partner ten gig not shown after page received");

endmodule : tpan_regs

// file: tpan_link_partner.sv
// far-side model: partner pages as the negotiation engine hands them over
module tpan_link_partner (
  // clock
  input wire logic clock,
  // page captures
  output logic base_load,
  output logic [15:0] base_word,
  output logic xnp_load,
  output logic [15:0] xnp_w1,
  output logic [15:0] xnp_w2,
  output logic [15:0] xnp_w3
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet start, no capture pending
  initial begin
    base_load = 1'b0;
    xnp_load = 1'b0;
    base_word = 16'h0000;
    xnp_w1 = 16'h0000;
    xnp_w2 = 16'h0000;
    xnp_w3 = 16'h0000;
  end

  // one-cycle capture; words invert after it so a late capture shows up
  task send_base(input logic [15:0] w);
    @(posedge clock);
    base_load <= 1'b1;
    base_word <= w;
    @(posedge clock);
    base_load <= 1'b0;
    base_word <= ~w;
  endtask : send_base

  // extended page: code bits 10:0, 26:11 and 42:27 across three words
  task send_xnp(input logic [15:0] w1, input logic [15:0] w2, input logic [15:0] w3);
    @(posedge clock);
    xnp_load <= 1'b1;
    xnp_w1 <= w1;
    xnp_w2 <= w2;
    xnp_w3 <= w3;
    @(posedge clock);
    xnp_load <= 1'b0;
    xnp_w1 <= ~w1;
    xnp_w2 <= ~w2;
    xnp_w3 <= ~w3;
  endtask : send_xnp
endmodule : tpan_link_partner

// file: tpan_regs_tb.sv
// self-checking bench for the auto-negotiation register bank
`include "tpan_map.svh"
module tpan_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // arbitrary package identifier for this run
  localparam logic [31:0] PKG = 32'h3c69_a512;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic mdc = 1'b1;
  logic mdio_drv = 1'b1;
  logic base_ack_in = 1'b0;
  logic xnp_sent = 1'b0;
  logic page_received = 1'b0;
  logic lp_ten_gig_in = 1'b0;
  logic loop_timing_cap = 1'b0;
  logic mdio_out, mdio_oe, lp_ten_gig_valid, bl, xl, smp;
  logic [15:0] bw, x1, x2, x3, adv, tx1, tx2, tx3, ctrl_word, q;
  tpan_pkg::tpan_role_t role_request;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  // bench drives the line whenever the bank is not driving, high between frames
  wire logic mdio_in = mdio_oe ? mdio_out : mdio_drv;

  tpan_regs #(.PKG_IDENT(PKG), .PORT_ADDR(5'h00)) dut (.clock(clock), .rst_b(rst_b),
    .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .base_ack_in(base_ack_in), .lp_base_load(bl), .lp_base_word(bw), .lp_xnp_load(xl),
    .lp_xnp_word1(x1), .lp_xnp_word2(x2), .lp_xnp_word3(x3), .xnp_sent(xnp_sent),
    .page_received(page_received), .lp_ten_gig_in(lp_ten_gig_in),
    .loop_timing_cap(loop_timing_cap), .base_page_adv(adv), .xnp_tx_word1(tx1),
    .xnp_tx_word2(tx2), .xnp_tx_word3(tx3), .ctrl_word(ctrl_word),
    .role_request(role_request), .lp_ten_gig_valid(lp_ten_gig_valid));
  tpan_link_partner lp (.clock(clock), .base_load(bl), .base_word(bw), .xnp_load(xl),
    .xnp_w1(x1), .xnp_w2(x2), .xnp_w3(x3));

  // ****************************************
  // clock, hang guard, reporting
  // ****************************************
  always #4 clock = ~clock;

  // ceiling well above the roughly 35k cycles the frames need
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // ****************************************
  // management frames
  // ****************************************
  // one bit: 5 clocks low, 5 high, so the synchroniser sees both edges
  task put(input logic b);
    mdc <= 1'b0;
    mdio_drv <= b;
    repeat (5) @(posedge clock);
    smp = mdio_in; // taken as mdc rises, before the bank lets go
    mdc <= 1'b1;
    repeat (5) @(posedge clock);
  endtask : put

  task frame(input logic [1:0] op, input logic [15:0] d);
    logic [13:0] hdr;
    hdr = {2'b00, op, 5'h00, `TPAN_DEVAD};
    for (int i = 0; i < 32; i++) put(1'b1);
    for (int i = 13; i >= 0; i--) put(hdr[i]);
    put(1'b1);
    put(op[1]); // turnaround low on writes, released on reads
    for (int i = 15; i >= 0; i--) begin
      put(op[1] | d[i]);
      q[i] = smp;
    end
    mdio_drv <= 1'b1;
    repeat (8) @(posedge clock);
  endtask : frame

  task wr(input logic [15:0] a, input logic [15:0] d);
    frame(`TPAN_OP_ADDR, a);
    frame(`TPAN_OP_WRITE, d);
  endtask : wr

  task rdc(input logic [15:0] a, input logic [15:0] e, input string nm);
    frame(`TPAN_OP_ADDR, a);
    frame(`TPAN_OP_READ, 16'h0000);
    chk(nm, e, q);
  endtask : rdc

  task tick(input logic sent);
    if (sent) xnp_sent <= 1'b1;
    else loop_timing_cap <= 1'b1;
    @(posedge clock);
    xnp_sent <= 1'b0;
    loop_timing_cap <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : tick

  // main sequence
  initial begin
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    chk("ctrl_word", 16'h1005, ctrl_word);
    chk("base adv", `TPAN_BASE_RST, adv);
    rdc(`TPAN_OFF_CTRL, 16'h1005, "ctrl");
    rdc(`TPAN_OFF_CTRL, 16'h1004, "ctrl cleared");
    tick(1'b0);
    rdc(`TPAN_OFF_CTRL, 16'h1005, "ctrl relatched");
    frame(`TPAN_OP_ADDR, `TPAN_OFF_PKG_LO);
    frame(`TPAN_OP_RINC, 16'h0000); // pointer steps to the high word
    chk("pkg low", PKG[15:0], q);
    frame(`TPAN_OP_READ, 16'h0000);
    chk("pkg high", PKG[31:16], q);
    base_ack_in <= 1'b1;
    wr(`TPAN_OFF_BASE, 16'hffff);
    rdc(`TPAN_OFF_BASE, 16'hffff, "base");
    base_ack_in <= 1'b0;
    wr(`TPAN_OFF_BASE, 16'h4aa5);
    rdc(`TPAN_OFF_BASE, 16'h0aa5, "base ro ack");
    chk("base adv", 16'h0aa5, adv);
    wr(`TPAN_OFF_CTRL, 16'hffff);
    rdc(`TPAN_OFF_CTRL, 16'hf1e4, "ctrl all");
    chk("role", 16'h0002, {14'h0000, role_request});
    wr(`TPAN_OFF_CTRL, 16'h8000);
    chk("ctrl_word", 16'h8000, ctrl_word);
    chk("role", 16'h0001, {14'h0000, role_request});
    wr(`TPAN_OFF_CTRL, 16'h4000);
    chk("role", 16'h0000, {14'h0000, role_request});
    wr(`TPAN_OFF_TX1, 16'hffff);
    rdc(`TPAN_OFF_TX1, 16'hb7ff, "tx1");
    tick(1'b1);
    rdc(`TPAN_OFF_TX1, 16'hbfff, "tx1 toggled");
    chk("tx1 word", 16'hbfff, tx1);
    wr(`TPAN_OFF_TX2, 16'h1234);
    wr(`TPAN_OFF_TX3, 16'h5678);
    chk("tx2", 16'h1234, tx2);
    chk("tx3 word", 16'h5678, tx3);
    rdc(`TPAN_OFF_TX3, 16'h5678, "tx3");
    lp.send_base(16'h9abc);
    rdc(`TPAN_OFF_LP_BASE, 16'h9abc, "lp base");
    lp.send_xnp(16'hfedc, 16'h2468, 16'h1357);
    wr(`TPAN_OFF_RX1, 16'h0000);
    rdc(`TPAN_OFF_RX1, 16'hfedc, "rx1");
    rdc(`TPAN_OFF_RX2, 16'h2468, "rx2");
    rdc(`TPAN_OFF_RX3, 16'h1357, "rx3");
    wr(`TPAN_OFF_RX2, 16'h0f0f);
    rdc(`TPAN_OFF_RX2, 16'h0f0f, "rx2 written");
    rdc(16'h0011, 16'h0000, "unmapped");
    lp_ten_gig_in <= 1'b1;
    repeat (3) @(posedge clock);
    chk("ten gig valid", 16'h0000, {15'h0000, lp_ten_gig_valid});
    page_received <= 1'b1;
    repeat (3) @(posedge clock);
    chk("ten gig valid", 16'h0001, {15'h0000, lp_ten_gig_valid});
    give_verdict();
  end
endmodule : tpan_regs_tb
